// ===== core/taw_pkg.sv
// Function
// [RULE1] lowest address bit absent, addresses even
// [RULE2] carry on low ones, borrow on zeros
// [RULE3] reverse code on go clear sets count down
// [RULE4] read bus muxes address or count, else floats
// [RULE5] address plus extension driven during transfers
// [RULE6] hidden drive counter governs the run line
// [RULE7] load two's complement, count up to zero
// [RULE8] counters load on full word write only
// [RULE9] drive counter steps without overflow or error
// [RULE10] step on trailing edge, top carry overflows
// [RULE11] word counters have no clear path
// [RULE12] primary init or power low inits drive bus
// [RULE13] combined clear from four sources
// [RULE14] go clear resets requests, clear resets all
// [RULE15] secondary init posts data late when active
// [RULE16] clears reset both overflows and done
// [RULE17] host overflow then done at request end
// [RULE18] error gives done, ready after end of segment
// [RULE19] drive carry sets last word, stops prefetch
// [RULE20] last word sampled, disables data late
// [RULE21] increment inhibit holds the address
// [RULE22] address counts down or up on strobe end
// [RULE23] each step moves byte address by two
package taw_pkg;
  localparam int ADDR_W = 15;
  localparam int WC_W = 16;
  localparam int DATA_W = 16;
  localparam int EXT_W = 2;
  localparam int LOW_SLICE_W = 3;
  localparam int REV_BIT_A = 1;
  localparam int REV_BIT_B = 2;
  localparam int CLEAR_BIT = 5;
  localparam int INHIBIT_BIT = 8;
  localparam int EXT_LSB = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [WC_W-1:0] WC_RST = 16'h0000;
  localparam logic [EXT_W-1:0] EXT_RST = 2'h0;
  localparam logic [LOW_SLICE_W-1:0] LOW_ONES = 3'h7;
  localparam logic [LOW_SLICE_W-1:0] LOW_ZEROS = 3'h0;
  localparam logic [WC_W-1:0] WC_LAST = 16'hFFFF;
endpackage : taw_pkg

// ===== core/taw_core.sv
`timescale 1ns/1ps
module taw_core (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic REG_STR,
  input wire logic BYTE_HI,
  input wire logic BYTE_LO,
  input wire logic SEL_ADDR,
  input wire logic SEL_WC,
  input wire logic SEL_CTL1,
  input wire logic SEL_CTL2,
  input wire logic [taw_pkg::DATA_W-1:0] DATA_IN,
  input wire logic GO_LOAD,
  input wire logic BUSA_INIT,
  input wire logic BUSA_POWER_LOW,
  input wire logic BUSB_INIT,
  input wire logic BUSB_POWER_LOW,
  input wire logic BUSB_ACTIVE,
  input wire logic ADDRESS_DRIVE_STROBE,
  input wire logic HOST_COUNT_STEP,
  input wire logic DRIVE_WORD_CLK,
  input wire logic DATA_REQ,
  input wire logic TRANSFER_ERROR,
  input wire logic DRIVE_ERROR,
  input wire logic END_OF_SEGMENT,
  input wire logic WRITE_XFER,
  input wire logic WORD_MISSING,
  output logic [taw_pkg::DATA_W-1:0] INTERNAL_READ_BUS,
  output logic INTERNAL_READ_BUS_OE,
  output logic [taw_pkg::ADDR_W:0] ADDR_OUT,
  output logic ADDRESS_EXTENSION_LOW,
  output logic ADDRESS_EXTENSION_HIGH,
  output logic COUNT_DOWN_FLAG,
  output logic INCREMENT_INHIBIT,
  output logic DRIVE_BUS_INITIALIZE,
  output logic COMBINED_CLEAR,
  output logic GO_CLEAR,
  output logic HOST_COUNT_OVERFLOW,
  output logic DRIVE_COUNT_OVERFLOW,
  output logic DONE,
  output logic READY,
  output logic RUN,
  output logic LAST_WORD,
  output logic PREFETCH_ENABLE,
  output logic DATA_LATE_ERROR
);
  import taw_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [EXT_W-1:0] ext;
    logic cdn;
    logic inh;
    logic [WC_W-1:0] hwc;
    logic [WC_W-1:0] dwc;
    logic hovf;
    logic dovf;
    logic done;
    logic rdy;
    logic err_wait;
    logic lw;
    logic dcarry;
    logic data_late_error;
    logic astb_p;
    logic hstb_p;
    logic dclk_p;
    logic dreq_p;
    logic init;
    logic clr;
    logic gclr;
    logic [DATA_W-1:0] rbus;
    logic rbus_oe;
  } taw_state_t;

  taw_state_t s_q, s_d;

  // one step of the address counter, low slice decoded separately
  function automatic logic [ADDR_W+EXT_W-1:0] addr_step(
    input logic [ADDR_W+EXT_W-1:0] v, input logic down);
    logic [LOW_SLICE_W-1:0] lo;
    logic [ADDR_W+EXT_W-LOW_SLICE_W-1:0] hi;
    logic carry;
    logic borrow;
    lo = v[LOW_SLICE_W-1:0];
    hi = v[ADDR_W+EXT_W-1:LOW_SLICE_W];
    carry = (lo == LOW_ONES); // [RULE2]
    borrow = (lo == LOW_ZEROS); // [RULE2]
    if (down) begin
      lo = lo - 3'h1;
      if (borrow) hi = hi - 1'b1;
    end else begin
      lo = lo + 3'h1;
      if (carry) hi = hi + 1'b1;
    end
    return {hi, lo};
  endfunction : addr_step

  // one word counter step: the low slice carry ripples into the high slice
  function automatic logic [WC_W-1:0] wc_step(
    input logic [WC_W-1:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = v[7:0] + 8'h01;
    hi = v[15:8];
    if (v[7:0] == 8'hFF) begin
      hi = hi + 8'h01; // [RULE10]
    end
    return {hi, lo};
  endfunction : wc_step

  logic wr_full_wc;
  logic a_fall;
  logic h_fall;
  logic d_fall;
  logic r_fall;
  logic prog_clr;
  logic go_clear;
  logic any_clr;
  logic [ADDR_W+EXT_W-1:0] stepped;

  // decoded write and read requests
  logic full_clr;
  logic rev_code;
  logic wr_addr_lo;
  logic wr_addr_hi;
  logic wr_ext;
  logic wr_inh;
  logic rd_addr;
  logic rd_wc;
  logic busb_clr;

  // counter steps and drive side qualifiers
  logic [WC_W-1:0] hwc_next;
  logic [WC_W-1:0] dwc_next;
  logic d_step;
  logic late_word;

  always_comb begin
    s_d = s_q;
    wr_full_wc = REG_STR && SEL_WC && BYTE_HI && BYTE_LO; // [RULE8]
    a_fall = s_q.astb_p && !ADDRESS_DRIVE_STROBE; // [RULE22]
    h_fall = s_q.hstb_p && !HOST_COUNT_STEP; // [RULE10]
    d_fall = s_q.dclk_p && !DRIVE_WORD_CLK; // [RULE10]
    r_fall = s_q.dreq_p && !DATA_REQ;
    prog_clr = REG_STR && SEL_CTL2 && BYTE_LO && DATA_IN[CLEAR_BIT];
    go_clear = GO_LOAD;
    // combined clear sources [RULE13]
    s_d.init = BUSA_INIT || BUSA_POWER_LOW; // [RULE12]
    s_d.clr = BUSA_INIT || BUSA_POWER_LOW || go_clear || prog_clr; // [RULE13]
    s_d.gclr = go_clear; // [RULE14]
    any_clr = s_d.clr;
    // a go load alone keeps the address; a program clear with it still wipes all
    full_clr = s_d.init || prog_clr; // [RULE14]
    rev_code = DATA_IN[REV_BIT_A] && DATA_IN[REV_BIT_B]; // [RULE3]
    wr_addr_lo = REG_STR && SEL_ADDR && BYTE_LO;
    wr_addr_hi = REG_STR && SEL_ADDR && BYTE_HI;
    // extension bits are written only while ready, so commands to other drives leave them alone
    wr_ext = REG_STR && SEL_CTL1 && BYTE_HI && s_q.rdy;
    wr_inh = REG_STR && SEL_CTL2 && BYTE_HI; // [RULE21]
    // a write cycle never drives the read bus
    rd_addr = SEL_ADDR && !REG_STR; // [RULE4]
    rd_wc = SEL_WC && !REG_STR && !SEL_ADDR; // [RULE4]
    // secondary bus init never clears registers, it only posts data late while the transfer is active
    busb_clr = BUSB_INIT || BUSB_POWER_LOW; // [RULE15]
    hwc_next = wc_step(s_q.hwc);
    dwc_next = wc_step(s_q.dwc);
    // drive counter freezes once it has overflowed, and while the drive reports an error
    d_step = d_fall && !s_q.dovf && !DRIVE_ERROR; // [RULE9]
    // strobes act on their trailing edge; the _p copies hold last cycle's level
    s_d.astb_p = ADDRESS_DRIVE_STROBE;
    s_d.hstb_p = HOST_COUNT_STEP;
    s_d.dclk_p = DRIVE_WORD_CLK;
    s_d.dreq_p = DATA_REQ;

    if (wr_inh) begin
      s_d.inh = DATA_IN[INHIBIT_BIT];
    end
    if (go_clear && rev_code) begin
      s_d.cdn = 1'b1; // [RULE3]
    end else if (go_clear) begin
      s_d.cdn = 1'b0;
    end

    // address counter: full clear, loads, then stepping
    stepped = addr_step({s_q.ext, s_q.addr}, s_q.cdn);
    if (full_clr) begin
      s_d.addr = ADDR_RST; // [RULE14]
      s_d.ext = EXT_RST;
    end else begin
      if (wr_addr_lo) begin
        s_d.addr[6:0] = DATA_IN[7:1]; // [RULE1]
      end
      if (wr_addr_hi) begin
        s_d.addr[ADDR_W-1:7] = DATA_IN[15:8];
      end
      if (wr_ext) begin
        s_d.ext = DATA_IN[EXT_LSB+EXT_W-1:EXT_LSB];
      end
      if (a_fall && !s_q.inh) begin // [RULE21]
        {s_d.ext, s_d.addr} = stepped; // [RULE22] [RULE23]
      end
    end

    // word counters: preload only, never cleared [RULE11]
    if (wr_full_wc) begin
      s_d.hwc = DATA_IN; // [RULE7] [RULE8]
      s_d.dwc = DATA_IN; // [RULE8]
    end else begin
      if (h_fall) begin
        s_d.hwc = hwc_next; // [RULE7] [RULE10]
      end
      if (d_step) begin // [RULE9]
        s_d.dwc = dwc_next; // [RULE6] [RULE7]
      end
    end

    // flags: a set in the clearing cycle wins [RULE16]
    if (any_clr) begin
      s_d.hovf = 1'b0; // [RULE16]
      s_d.dovf = 1'b0; // [RULE16]
      s_d.done = 1'b0; // [RULE16]
      s_d.rdy = 1'b0;
      s_d.err_wait = 1'b0;
      s_d.lw = 1'b0;
      s_d.dcarry = 1'b0;
    end
    if (!wr_full_wc && h_fall && s_q.hwc == WC_LAST) begin
      s_d.hovf = 1'b1; // [RULE10] [RULE17]
    end
    // drive carry is held as last word until the next clear
    if (!wr_full_wc && d_step && s_q.dwc == WC_LAST) begin
      s_d.dovf = 1'b1; // [RULE10]
      s_d.dcarry = 1'b1; // [RULE19]
    end
    if (d_fall) begin
      s_d.lw = s_q.dcarry || s_d.dcarry; // [RULE20]
    end
    if (r_fall && (s_q.hovf || TRANSFER_ERROR)) begin
      s_d.done = 1'b1; // [RULE17] [RULE18]
      if (TRANSFER_ERROR && !END_OF_SEGMENT) begin
        s_d.err_wait = 1'b1; // [RULE18]
      end else begin
        s_d.rdy = 1'b1;
      end
    end
    if (s_q.err_wait && END_OF_SEGMENT) begin
      s_d.err_wait = 1'b0;
      s_d.rdy = 1'b1; // [RULE18]
    end

    // data late error; full clear resets it, set wins
    if (full_clr) begin
      s_d.data_late_error = 1'b0;
    end
    if (busb_clr && BUSB_ACTIVE) begin
      s_d.data_late_error = 1'b1; // [RULE15]
    end
    // a missing word on the final drive clock is not late
    late_word = d_fall && WORD_MISSING && !s_q.lw && !s_d.lw; // [RULE20]
    if (late_word) begin
      s_d.data_late_error = 1'b1; // [RULE20]
    end

    // register read mux, floats when nothing selected
    s_d.rbus = '0;
    s_d.rbus_oe = 1'b0;
    if (rd_addr) begin
      s_d.rbus = {s_q.addr, 1'b0}; // [RULE4] [RULE1]
      s_d.rbus_oe = 1'b1; // [RULE4]
    end else if (rd_wc) begin
      s_d.rbus = s_q.hwc; // [RULE4]
      s_d.rbus_oe = 1'b1; // [RULE4]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_q <= '0;
      s_q.addr <= ADDR_RST;
      s_q.ext <= EXT_RST;
      s_q.hwc <= WC_RST;
      s_q.dwc <= WC_RST;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign INTERNAL_READ_BUS = s_q.rbus;
  assign INTERNAL_READ_BUS_OE = s_q.rbus_oe;
  assign ADDR_OUT = {s_q.addr, 1'b0}; // [RULE1] [RULE5]
  assign ADDRESS_EXTENSION_LOW = s_q.ext[0]; // [RULE5]
  assign ADDRESS_EXTENSION_HIGH = s_q.ext[1]; // [RULE5]
  assign COUNT_DOWN_FLAG = s_q.cdn;
  assign INCREMENT_INHIBIT = s_q.inh;
  assign DRIVE_BUS_INITIALIZE = s_q.init; // [RULE12]
  assign COMBINED_CLEAR = s_q.clr; // [RULE14]
  assign GO_CLEAR = s_q.gclr; // [RULE14]
  assign HOST_COUNT_OVERFLOW = s_q.hovf;
  assign DRIVE_COUNT_OVERFLOW = s_q.dovf;
  assign DONE = s_q.done;
  assign READY = s_q.rdy;
  assign RUN = !s_q.dovf; // [RULE6]
  assign LAST_WORD = s_q.dcarry; // [RULE19]
  assign PREFETCH_ENABLE = WRITE_XFER && !s_q.dcarry; // [RULE19]
  assign DATA_LATE_ERROR = s_q.data_late_error;
endmodule : taw_core

// ===== tb/taw_checker.sv
`timescale 1ns/1ps
module taw_checker (
  input wire logic CLK, RSTN, REG_STR, SEL_ADDR, GO_LOAD, BUSA_INIT, BUSA_POWER_LOW, BUSB_INIT, BUSB_ACTIVE,
  input wire logic ADDRESS_DRIVE_STROBE, HOST_COUNT_STEP, DRIVE_WORD_CLK, DATA_REQ, WRITE_XFER,
  input wire logic INTERNAL_READ_BUS_OE, COUNT_DOWN_FLAG, INCREMENT_INHIBIT, DRIVE_BUS_INITIALIZE,
  input wire logic HOST_COUNT_OVERFLOW, DRIVE_COUNT_OVERFLOW, DONE, LAST_WORD, PREFETCH_ENABLE, DATA_LATE_ERROR,
  input wire logic [taw_pkg::DATA_W-1:0] DATA_IN, INTERNAL_READ_BUS,
  input wire logic [taw_pkg::ADDR_W:0] ADDR_OUT
);
  import taw_pkg::*;
  // no write or clear source this cycle
  wire q = !(REG_STR || GO_LOAD || BUSA_INIT || BUSA_POWER_LOW);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_ADDR_EVEN: assert property (ADDR_OUT[0] == 1'h0)
    else $error("odd address");
  AST_ADDR_UP: assert property ($fell(ADDRESS_DRIVE_STROBE) && q && !INCREMENT_INHIBIT && !COUNT_DOWN_FLAG
    |=> ADDR_OUT == $past(ADDR_OUT) + 16'h0002) else $error("address up step wrong");
  AST_ADDR_DOWN: assert property ($fell(ADDRESS_DRIVE_STROBE) && q && !INCREMENT_INHIBIT && COUNT_DOWN_FLAG
    |=> ADDR_OUT == $past(ADDR_OUT) - 16'h0002) else $error("address down step wrong");
  AST_INHIBIT: assert property ($fell(ADDRESS_DRIVE_STROBE) && q && INCREMENT_INHIBIT |=> $stable(ADDR_OUT))
    else $error("address moved while inhibited");
  AST_REVERSE: assert property (GO_LOAD && DATA_IN[2:1] == 2'h3 |=> COUNT_DOWN_FLAG)
    else $error("reverse load missed");
  AST_DRIVE_INIT: assert property (BUSA_INIT || BUSA_POWER_LOW |=> DRIVE_BUS_INITIALIZE)
    else $error("drive bus init missing");
  AST_CLEAR_FLAGS: assert property ((GO_LOAD || BUSA_INIT) && !$fell(DATA_REQ) && !$fell(HOST_COUNT_STEP)
    && !$fell(DRIVE_WORD_CLK) |=> !DONE && !HOST_COUNT_OVERFLOW && !DRIVE_COUNT_OVERFLOW) else $error("flags kept");
  AST_READ_ADDR: assert property (SEL_ADDR && !REG_STR |=> INTERNAL_READ_BUS_OE && INTERNAL_READ_BUS == $past(ADDR_OUT))
    else $error("address read wrong");
  AST_PREFETCH: assert property (PREFETCH_ENABLE == (WRITE_XFER && !LAST_WORD))
    else $error("prefetch wrong");
  AST_LATE: assert property (BUSB_INIT && BUSB_ACTIVE |=> DATA_LATE_ERROR)
    else $error("data late missing");
  AST_DONE: assert property ($fell(DATA_REQ) && HOST_COUNT_OVERFLOW |=> DONE)
    else $error("done missing");
endmodule : taw_checker
bind taw_core taw_checker u_chk (.*);

// ===== tb/taw_drive_model.sv
`timescale 1ns/1ps
module taw_drive_model (
  input wire logic CLK,
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] words,
  output logic DRIVE_WORD_CLK,
  output logic busy
);
  initial begin
    DRIVE_WORD_CLK = 1'h0;
    busy = 1'h0;
    forever begin
      @(posedge CLK);
      if (start) begin
        busy <= 1'h1;
        repeat (words) begin
          @(posedge CLK) DRIVE_WORD_CLK <= 1'h1;
          @(posedge CLK) DRIVE_WORD_CLK <= 1'h0;
          repeat (slow ? 4 : 1) @(posedge CLK);
        end
        busy <= 1'h0;
      end
    end
  end
endmodule : taw_drive_model

// ===== tb/transfer_address_word_count_test.sv
`timescale 1ns/1ps
module transfer_address_word_count_test;
  import taw_pkg::*;
  logic CLK, RSTN, REG_STR, BYTE_HI, BYTE_LO, GO_LOAD, go, slow, busy;
  logic [3:0] sel;
  logic [2:0] stb;
  logic [9:0] lv;
  logic [7:0] nw;
  logic [DATA_W-1:0] DATA_IN, INTERNAL_READ_BUS;
  logic [ADDR_W:0] ADDR_OUT;
  logic SEL_ADDR, SEL_WC, SEL_CTL1, SEL_CTL2, BUSA_INIT, BUSA_POWER_LOW, BUSB_INIT, BUSB_POWER_LOW, BUSB_ACTIVE;
  logic ADDRESS_DRIVE_STROBE, HOST_COUNT_STEP, DRIVE_WORD_CLK, DATA_REQ, TRANSFER_ERROR, DRIVE_ERROR;
  logic END_OF_SEGMENT, WRITE_XFER, WORD_MISSING, INTERNAL_READ_BUS_OE, ADDRESS_EXTENSION_LOW, ADDRESS_EXTENSION_HIGH;
  logic COUNT_DOWN_FLAG, INCREMENT_INHIBIT, DRIVE_BUS_INITIALIZE, COMBINED_CLEAR, GO_CLEAR, HOST_COUNT_OVERFLOW;
  logic DRIVE_COUNT_OVERFLOW, DONE, READY, RUN, LAST_WORD, PREFETCH_ENABLE, DATA_LATE_ERROR;
  int miscompares, checks_done, seed, ea, ew, n, t;
  assign {SEL_ADDR, SEL_WC, SEL_CTL1, SEL_CTL2} = sel;
  assign {DATA_REQ, HOST_COUNT_STEP, ADDRESS_DRIVE_STROBE} = stb;
  assign {BUSA_INIT, BUSA_POWER_LOW, BUSB_INIT, BUSB_POWER_LOW, BUSB_ACTIVE, TRANSFER_ERROR, DRIVE_ERROR,
    END_OF_SEGMENT, WRITE_XFER, WORD_MISSING} = lv;
  taw_core uut (.*);
  taw_drive_model dm (.CLK(CLK), .start(go), .slow(slow), .words(nw), .DRIVE_WORD_CLK(DRIVE_WORD_CLK), .busy(busy));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] s, input logic [15:0] d, input logic [1:0] b);
    @(posedge CLK) {REG_STR, sel, DATA_IN, BYTE_HI, BYTE_LO} <= {1'h1, s, d, b};
    @(posedge CLK) {REG_STR, sel} <= 5'h00;
    @(posedge CLK) #1;
  endtask : wr
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(posedge CLK) sel <= s;
    @(posedge CLK) sel <= 4'h0;
    #1 chk({INTERNAL_READ_BUS_OE, INTERNAL_READ_BUS}, e);
  endtask : rd
  task automatic p(input int i);
    @(posedge CLK) stb[i] <= 1'h1;
    @(posedge CLK) stb[i] <= 1'h0;
    @(posedge CLK) #1;
  endtask : p
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    results();
  end
  initial begin
    {RSTN, REG_STR, BYTE_HI, BYTE_LO, GO_LOAD, go, slow, sel, stb, lv, nw, DATA_IN} = '0;
    seed = 32'h100348a5;
    repeat (20) @(posedge CLK);
    RSTN <= 1'h1;
    @(posedge CLK) #1 chk({READY, RUN, ADDR_OUT}, 32'h30000);
    ea = 32'hFFF0 | ($random(seed) & 14);
    n = 8 + ($random(seed) & 3);
    wr(4'h8, ea[15:0], 2'h3);
    repeat (n) begin
      p(0);
      ea = (ea + 2) & 32'h3FFFF;
      chk({ADDRESS_EXTENSION_HIGH, ADDRESS_EXTENSION_LOW, ADDR_OUT}, ea);
    end
    rd(4'h8, 32'h10000 | (ea & 32'hFFFF));
    @(posedge CLK) {GO_LOAD, DATA_IN} <= {1'h1, 16'h0006};
    @(posedge CLK) GO_LOAD <= 1'h0;
    #1 chk({COMBINED_CLEAR, GO_CLEAR}, 2'h3);
    @(posedge CLK) #1 chk(COUNT_DOWN_FLAG, 1);
    repeat (n) begin
      p(0);
      ea = (ea - 2) & 32'h3FFFF;
      chk({ADDRESS_EXTENSION_HIGH, ADDRESS_EXTENSION_LOW, ADDR_OUT}, ea);
    end
    wr(4'h1, 16'h0100, 2'h2);
    p(0);
    chk({INCREMENT_INHIBIT, ADDRESS_EXTENSION_HIGH, ADDRESS_EXTENSION_LOW, ADDR_OUT}, 32'h40000 | ea);
    wr(4'h1, 16'h0000, 2'h2);
    $display("address tests done");
    n = 2 + ($random(seed) & 7);
    ew = (-n) & 32'hFFFF;
    wr(4'h4, 16'h1234, 2'h1);
    rd(4'h4, 32'h10000);
    wr(4'h4, ew[15:0], 2'h3);
    repeat (n) begin
      chk(HOST_COUNT_OVERFLOW, 0);
      p(1);
      ew = (ew + 1) & 32'hFFFF;
    end
    chk(HOST_COUNT_OVERFLOW, 1);
    rd(4'h4, 32'h10000 | ew);
    t = $random(seed);
    @(posedge CLK) {go, slow, nw, lv} <= {1'h1, t[0], n[7:0], 10'h002};
    @(posedge CLK) go <= 1'h0;
    @(posedge CLK);
    t = 0;
    while (busy === 1'h1 && t < 500) begin
      @(posedge CLK);
      t++;
    end
    #1 chk({DRIVE_COUNT_OVERFLOW, LAST_WORD, RUN, PREFETCH_ENABLE}, 4'hC);
    p(2);
    chk({DONE, READY}, 2'h3);
    $display("count tests done");
    wr(4'h1, 16'h0020, 2'h1);
    chk({HOST_COUNT_OVERFLOW, DRIVE_COUNT_OVERFLOW, DONE, READY, ADDR_OUT}, 32'h0);
    rd(4'h4, 32'h10000 | ew);
    @(posedge CLK) lv <= 10'h010;
    p(2);
    chk({DONE, READY}, 2'h2);
    @(posedge CLK) lv <= 10'h014;
    repeat (2) @(posedge CLK);
    #1 chk(READY, 1);
    @(posedge CLK) lv <= 10'h100;
    @(posedge CLK) lv <= 10'h0A0;
    #1 chk(DRIVE_BUS_INITIALIZE, 1);
    @(posedge CLK) lv <= 10'h000;
    #1 chk(DATA_LATE_ERROR, 1);
    $display("clear tests done");
    results();
  end
endmodule : transfer_address_word_count_test
